/* File: hw/ldo_pkg.sv */
// package for the regulator mode target: map, encodings, reset values
// assumes one system clock; bus pins are synchronised in the target
package ldo_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [10:0] ADDR_MODE = 11'h0f4;
	localparam int MODE_BIT = 0;
	localparam logic MODE_RESET = 1'b0;
	// block address bits this target answers to
	localparam logic [2:0] DEV_BLOCK = 3'h0;

	// ---------------------------------------------------------------
	// bus values
	// ---------------------------------------------------------------
	localparam logic [1:0] BUS_IDLE = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RECV = 7'h02,
		ST_ACKW = 7'h04,
		ST_ACK = 7'h08,
		ST_SEND = 7'h10,
		ST_MACKW = 7'h20,
		ST_MACK = 7'h40
	} ldo_state_t;

	typedef enum logic [1:0] {
		K_CTRL = 2'h0,
		K_WADDR = 2'h1,
		K_WDATA = 2'h2,
		K_DONE = 2'h3
	} ldo_kind_t;

endpackage : ldo_pkg

/* File: hw/ldo_sync.sv */
// two flip-flop synchroniser for inputs from outside clk_sys
// assumes the reset value is the idle level of the inputs
`timescale 1ns/1ps
`default_nettype none
module ldo_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_reg <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : ldo_sync
`default_nettype wire

/* File: hw/ldo_i2c_target.sv */
// i2c target holding the regulator mode select byte
// assumes scl/sda arrive asynchronously; sda is open drain outside
//
// Operation
// [RULE1] control byte starts with configurable code
// [RULE2] then block address bits and read/write
// [RULE3] acknowledge a control byte addressed here
// [RULE4] controller sends word address after control
// [RULE5] pointer is block bits plus word address
// [RULE6] byte write: ack address, ack data, stop
// [RULE7] write commits when data ack driven
// [RULE8] repeated start aborts write, keeps pointer
// [RULE9] read control byte acked, eight bits out
// [RULE10] bit zero at 0xf4 selects level
// [RULE11] mode set by write to 0xf4
// [RULE12] mode read by random read of 0xf4
// [RULE13] no acknowledge on code or address mismatch
// [RULE14] upper seven mode bits ignored, read zero
`timescale 1ns/1ps
`default_nettype none
module ldo_i2c_target (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [3:0] cfg_ctrl_code,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic mode_select_bit
);
	import ldo_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisation and bus conditions
	// ---------------------------------------------------------------
	logic scl_s, sda_s, scl_d, sda_d;
	logic scl_rise, scl_fall, start_det, stop_det;

	ldo_sync #(.WIDTH(2), .RST_VAL(BUS_IDLE)) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d({scl_in, sda_in}),
		.q({scl_s, sda_s})
	);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// ---------------------------------------------------------------
	// register read view
	// ---------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [10:0] addr);
		logic [7:0] b;
		b = BYTE_ZERO;
		// [RULE14] upper bits zero
		if (addr == ADDR_MODE) begin
			b[MODE_BIT] = mode_select_bit;
		end
		return b;
	endfunction : read_byte

	// ---------------------------------------------------------------
	// protocol engine
	// ---------------------------------------------------------------
	ldo_state_t st_reg, st_next;
	ldo_kind_t kind_reg, kind_next;
	logic [2:0] cnt_reg, cnt_next, tx_idx;
	logic [7:0] rx_reg, rx_next, tx_reg, tx_next;
	logic [10:0] ptr_reg, ptr_next;
	logic [2:0] blk_reg, blk_next;
	logic rd_reg, rd_next, mode_next, oe_n_next, addr_match;

	assign tx_idx = BIT_LAST - cnt_reg;
	// [RULE1] code compare
	assign addr_match = (rx_reg[7:4] == cfg_ctrl_code) &&
		(rx_reg[3:1] == DEV_BLOCK);

	always_comb begin
		st_next = st_reg;
		kind_next = kind_reg;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		blk_next = blk_reg;
		rd_next = rd_reg;
		mode_next = mode_select_bit;
		oe_n_next = sda_oe_n;
		if (stop_det) begin
			st_next = ST_IDLE;
			oe_n_next = 1'b1;
		end else if (start_det) begin
			// [RULE8] restart drops pending write
			st_next = ST_RECV;
			kind_next = K_CTRL;
			cnt_next = BIT_FIRST;
			oe_n_next = 1'b1;
		end else begin
			case (st_reg)
				ST_RECV: begin
					if (scl_rise) begin
						rx_next = {rx_reg[6:0], sda_s};
						if (cnt_reg == BIT_LAST) begin
							st_next = ST_ACKW;
							cnt_next = BIT_FIRST;
						end else begin
							cnt_next = cnt_reg + 3'h1;
						end
					end
				end
				ST_ACKW: begin
					if (scl_fall) begin
						case (kind_reg)
							K_CTRL: begin
								// [RULE3] ack when addressed
								// [RULE13] else stay released
								if (addr_match) begin
									oe_n_next = 1'b0;
									st_next = ST_ACK;
									// [RULE2] block bits and direction
									blk_next = rx_reg[3:1];
									rd_next = rx_reg[0];
								end else begin
									st_next = ST_IDLE;
								end
							end
							K_WADDR: begin
								// [RULE5] pointer load
								oe_n_next = 1'b0;
								st_next = ST_ACK;
								ptr_next = {blk_reg, rx_reg};
							end
							K_WDATA: begin
								// [RULE7] commit with ack
								// [RULE10] mode bit store
								oe_n_next = 1'b0;
								st_next = ST_ACK;
								if (ptr_reg == ADDR_MODE) begin
									mode_next = rx_reg[MODE_BIT];
								end
							end
							default: begin
								st_next = ST_IDLE;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_n_next = 1'b1;
						st_next = ST_RECV;
						cnt_next = BIT_FIRST;
						case (kind_reg)
							K_CTRL: begin
								if (rd_reg) begin
									// [RULE9] first read bit out
									st_next = ST_SEND;
									tx_next = read_byte(ptr_reg);
									oe_n_next = tx_next[7];
								end else begin
									kind_next = K_WADDR;
								end
							end
							K_WADDR: begin
								// [RULE6] expect one data byte
								kind_next = K_WDATA;
							end
							default: begin
								kind_next = K_DONE;
							end
						endcase
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						oe_n_next = tx_reg[tx_idx];
					end else if (scl_rise) begin
						if (cnt_reg == BIT_LAST) begin
							st_next = ST_MACKW;
						end else begin
							cnt_next = cnt_reg + 3'h1;
						end
					end
				end
				ST_MACKW: begin
					if (scl_fall) begin
						oe_n_next = 1'b1;
						st_next = ST_MACK;
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						if (!sda_s) begin
							ptr_next = ptr_reg + 11'h001;
							tx_next = read_byte(ptr_next);
							cnt_next = BIT_FIRST;
							st_next = ST_SEND;
						end else begin
							st_next = ST_IDLE;
						end
					end
				end
				default: begin
					st_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_reg <= ST_IDLE;
			kind_reg <= K_CTRL;
			cnt_reg <= BIT_FIRST;
			rx_reg <= BYTE_ZERO;
			tx_reg <= BYTE_ZERO;
			ptr_reg <= 11'h000;
			blk_reg <= DEV_BLOCK;
			rd_reg <= 1'b0;
			mode_select_bit <= MODE_RESET;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			st_reg <= st_next;
			kind_reg <= kind_next;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			blk_reg <= blk_next;
			rd_reg <= rd_next;
			mode_select_bit <= mode_next;
			sda_oe_n <= oe_n_next;
			sda_out <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_ackw_fall(ldo_kind_t k);
		st_reg == ST_ACKW && kind_reg == k && scl_fall && !start_det &&
			!stop_det;
	endsequence

	chk_ctrl_ack: assert property ( // [RULE3]
		s_ackw_fall(K_CTRL) ##0 addr_match |=> !sda_oe_n)
		else $error("addressed control byte not acknowledged");
	chk_ctrl_nack: assert property ( // [RULE13]
		s_ackw_fall(K_CTRL) ##0 !addr_match |=> sda_oe_n ##1 sda_oe_n)
		else $error("foreign control byte acknowledged");
	chk_code_field: assert property ( // [RULE1]
		st_reg == ST_ACK && kind_reg == K_CTRL |->
			rx_reg[7:4] == cfg_ctrl_code)
		else $error("ack given with wrong control code");
	chk_rw_route: assert property ( // [RULE2]
		st_reg == ST_ACK && kind_reg == K_CTRL && scl_fall && rd_reg &&
			!start_det && !stop_det |=> st_reg == ST_SEND)
		else $error("read bit did not start a read");
	chk_ptr_load: assert property ( // [RULE5]
		s_ackw_fall(K_WADDR) |=>
			ptr_reg == {$past(blk_reg), $past(rx_reg)})
		else $error("pointer not loaded from address");
	chk_waddr_ack: assert property ( // [RULE6]
		s_ackw_fall(K_WADDR) |=> !sda_oe_n ##1 !sda_oe_n)
		else $error("word address not acknowledged");
	chk_write_commit: assert property ( // [RULE7]
		s_ackw_fall(K_WDATA) ##0 ptr_reg == ADDR_MODE |=>
			mode_select_bit == rx_reg[MODE_BIT] && !sda_oe_n)
		else $error("data not committed with its ack");
	chk_restart_keep: assert property ( // [RULE8]
		start_det && kind_reg == K_WDATA |=>
			$stable(mode_select_bit) && $stable(ptr_reg))
		else $error("restart disturbed mode or pointer");
	chk_read_first: assert property ( // [RULE9]
		st_reg == ST_ACK && kind_reg == K_CTRL && rd_reg && scl_fall &&
			!start_det && !stop_det |=> sda_oe_n == tx_reg[7])
		else $error("first read bit wrong");
	chk_mode_reset: assert property ( // [RULE10]
		$rose(rstn) |-> mode_select_bit == MODE_RESET)
		else $error("mode select not at default");
	chk_upper_zero: assert property ( // [RULE14]
		st_reg == ST_SEND && ptr_reg == ADDR_MODE |->
			tx_reg[7:1] == 7'h00)
		else $error("upper mode bits not zero");
endmodule : ldo_i2c_target
`default_nettype wire

/* File: test/ldo_ctl_model.sv */
// i2c bus controller model driving the mode target's pins
// assumes a pull-up on sda; the target never stretches scl
`timescale 1ns/1ps
`default_nettype none
module ldo_ctl_model (
	input wire logic clk_sys,
	input wire logic sda,
	output logic scl,
	output logic sda_dn
);
	// ---------------------------------------------------------------
	// bit timing: scl low 5, high 3 clk_sys cycles (200 ns)
	// ---------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_dn = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	task automatic bit_io(input logic b, output logic r);
		sda_dn <= !b;
		wt(4);
		scl <= 1'b1;
		wt(2);
		r = sda;
		wt(1);
		scl <= 1'b0;
		wt(1);
	endtask : bit_io
	// long low phase lets the target drop a pending ack first
	task automatic start();
		sda_dn <= 1'b0;
		wt(5);
		scl <= 1'b1;
		wt(3);
		sda_dn <= 1'b1;
		wt(3);
		scl <= 1'b0;
		wt(1);
	endtask : start
	task automatic stop();
		sda_dn <= 1'b1;
		wt(5);
		scl <= 1'b1;
		wt(3);
		sda_dn <= 1'b0;
		wt(8);
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : wbyte
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!mack, r);
	endtask : rbyte
endmodule : ldo_ctl_model
`default_nettype wire

/* File: test/ldo_i2c_target_bench.sv */
// self-checking bench for the regulator mode target
// assumes the controller model and an open-drain sda with pull-up
`timescale 1ns/1ps
`default_nettype none
module ldo_i2c_target_bench;
	import ldo_pkg::*;
	logic clk_sys, rstn, scl, sda_dn, sda_out, sda_oe_n, mode_select_bit;
	logic [3:0] cfg_ctrl_code;
	logic [7:0] rnd;
	int err_count, tests_run, mode_exp, ptr_exp;
	int exp_q[$];
	wire logic sda;
	assign sda = !(sda_dn || (!sda_oe_n && !sda_out));
	ldo_i2c_target uut (.clk_sys(clk_sys), .rstn(rstn),
		.cfg_ctrl_code(cfg_ctrl_code), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.mode_select_bit(mode_select_bit));
	ldo_ctl_model ctl (.clk_sys(clk_sys), .sda(sda), .scl(scl),
		.sda_dn(sda_dn));
	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// reference view: only bit zero of the mode byte exists
	function automatic logic [7:0] exp_byte(input int p);
		return (p == ADDR_MODE) ? 8'(mode_exp) : 8'h00;
	endfunction : exp_byte
	task automatic wr(input logic [7:0] c, input logic [7:0] w,
		input logic [7:0] d, input logic hit);
		logic a;
		ctl.start();
		ctl.wbyte(c, a);
		check("ack ctrl", {7'h0, hit}, {7'h0, a});
		if (hit) begin
			ctl.wbyte(w, a);
			check("ack waddr", 8'h01, {7'h0, a});
			ctl.wbyte(d, a);
			check("ack data", 8'h01, {7'h0, a});
			ptr_exp = int'(w);
			if (ptr_exp == ADDR_MODE)
				mode_exp = int'(d[0]);
		end
		check("mode", 8'(mode_exp), {7'h0, mode_select_bit});
		ctl.stop();
	endtask : wr
	// junk data bits before the restart must not be stored
	task automatic rd(input logic [7:0] c, input logic [7:0] w,
		input int part, input logic more);
		logic a, r;
		logic [7:0] d;
		ctl.start();
		ctl.wbyte(c, a);
		ctl.wbyte(w, a);
		ptr_exp = int'(w);
		for (int i = 0; i < part; i++) begin
			ctl.bit_io(!mode_exp[0], r);
		end
		ctl.start();
		ctl.wbyte(c | 8'h01, a);
		check("ack read", 8'h01, {7'h0, a});
		exp_q.push_back(exp_byte(ptr_exp));
		if (more) begin
			ptr_exp++;
			exp_q.push_back(exp_byte(ptr_exp));
		end
		ctl.rbyte(more, d);
		check("read", 8'(exp_q.pop_front()), d);
		if (more) begin
			ctl.rbyte(1'b0, d);
			check("read next", 8'(exp_q.pop_front()), d);
		end
		ctl.stop();
		check("kept", 8'(mode_exp), {7'h0, mode_select_bit});
	endtask : rd
	// current-address read: no word address, pointer as left before
	task automatic cur_rd(input logic [7:0] c);
		logic a;
		logic [7:0] d;
		ctl.start();
		ctl.wbyte(c | 8'h01, a);
		check("ack cur", 8'h01, {7'h0, a});
		ctl.rbyte(1'b0, d);
		ctl.stop();
		check("read cur", exp_byte(ptr_exp), d);
	endtask : cur_rd
	// ---------------------------------------------------------------
	// clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = !clk_sys;
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		tally_and_finish();
	end
	initial begin
		rstn = 1'b0;
		cfg_ctrl_code = 4'he;
		rnd = 8'h54;
		mode_exp = 0;
		ptr_exp = 0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		ctl.wt(6);
		check("reset", 8'h00, {7'h0, mode_select_bit});
		rd(8'he0, 8'hf4, 0, 1'b0);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			wr(8'he0, 8'hf4, rnd, 1'b1);
			rd(8'he0, 8'hf4, k + 2, k[0]);
		end
		cur_rd(8'he0);
		rd(8'he0, 8'hf4, 0, 1'b0);
		cur_rd(8'he0);
		wr(8'he0, 8'hf5, {rnd[7:1], !mode_exp[0]}, 1'b1);
		rd(8'he0, 8'hf5, 0, 1'b0);
		wr(8'ha0, 8'hf4, {rnd[7:1], !mode_exp[0]}, 1'b0);
		wr(8'he2, 8'hf4, {rnd[7:1], !mode_exp[0]}, 1'b0);
		wr(8'he0, 8'hf4, 8'hff, 1'b1);
		rd(8'he0, 8'hf4, 0, 1'b0);
		// reset in mid-run with the mode set must bring it back to default
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		mode_exp = 0;
		ctl.wt(6);
		check("reset again", 8'h00, {7'h0, mode_select_bit});
		rd(8'he0, 8'hf4, 0, 1'b0);
		@(posedge clk_sys);
		cfg_ctrl_code <= 4'h5;
		wr(8'he0, 8'hf4, {rnd[7:1], !mode_exp[0]}, 1'b0);
		wr(8'h50, 8'hf4, {rnd[7:1], !mode_exp[0]}, 1'b1);
		rd(8'h50, 8'hf4, 0, 1'b0);
		tally_and_finish();
	end
endmodule : ldo_i2c_target_bench
`default_nettype wire
